/* common/request_filter_pkg.sv */
// Purpose: shared constants and types for the per-node request filter block
// Assumes: byte addressed register window, 32-bit data words
// Notes: node id layout is bus number above a six bit node number
package request_filter_pkg;

   localparam int DATA_W = 32;
   localparam int ADDR_W = 9;
   localparam int BUS_W = 10;
   localparam int NODE_W = 6;
   localparam int SRC_W = BUS_W + NODE_W;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_ASYNC_HIGH_SET = 9'h100;
   localparam logic [ADDR_W-1:0] OFF_ASYNC_HIGH_CLR = 9'h104;
   localparam logic [ADDR_W-1:0] OFF_ASYNC_LOW_SET = 9'h108;
   localparam logic [ADDR_W-1:0] OFF_ASYNC_LOW_CLR = 9'h10C;
   localparam logic [ADDR_W-1:0] OFF_PHYS_HIGH_SET = 9'h110;
   localparam logic [ADDR_W-1:0] OFF_PHYS_HIGH_CLR = 9'h114;
   localparam logic [ADDR_W-1:0] OFF_PHYS_LOW_SET = 9'h118;
   localparam logic [ADDR_W-1:0] OFF_PHYS_LOW_CLR = 9'h11C;
   localparam logic [ADDR_W-1:0] OFF_FILTER_STATUS = 9'h120;

   // reset values and field positions
   localparam logic [DATA_W-1:0] FILTER_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] REMOTE_BUS_MASK = 32'h8000_0000;
   localparam int REMOTE_BUS_BIT = 31;
   localparam int STATUS_REFUSE_LSB = 16;
   localparam logic [15:0] COUNT_RESET = 16'h0000;

   // node id encodings
   localparam logic [BUS_W-1:0] LOCAL_BUS_ALIAS = 10'h3FF;
   localparam logic [NODE_W-1:0] NODE_BROADCAST = 6'h3F;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ANSWER = 2'b10
   } bus_state_t;

endpackage

/* src/request_node_filter.sv */
// Purpose: per-node receive request filtering with set/clear register aliases
// Assumes: request inputs and bus reset come from logic on clk_sys
// Notes: one request decision per cycle, answered one cycle after it is taken
`timescale 1ns/100ps
`default_nettype none

module request_node_filter
   import request_filter_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [BUS_W-1:0] local_bus_id,
   input wire logic serial_bus_reset,
   input wire logic req_valid,
   input wire logic [SRC_W-1:0] req_src_id,
   input wire logic req_to_phys,
   output logic dec_valid,
   output logic dec_accept,
   output logic dec_to_phys,
   output logic dec_to_async_ctx
);

   logic [DATA_W-1:0] async_high_reg;
   logic [DATA_W-1:0] async_low_reg;
   logic [DATA_W-1:0] phys_high_reg;
   logic [DATA_W-1:0] phys_low_reg;
   logic [DATA_W-1:0] async_high_next;
   logic [DATA_W-1:0] async_low_next;
   logic [DATA_W-1:0] phys_high_next;
   logic [DATA_W-1:0] phys_low_next;
   logic [15:0] accept_cnt_reg;
   logic [15:0] refuse_cnt_reg;
   bus_state_t bus_state_reg;
   logic wr_fire;
   logic [DATA_W-1:0] wr_bits;
   logic [DATA_W-1:0] rd_value;
   logic src_local;
   logic async_bit;
   logic phys_bit;
   logic accept_next;
   logic to_phys_next;

   function automatic logic node_bit(input logic [DATA_W-1:0] hi,
                                     input logic [DATA_W-1:0] lo,
                                     input logic [NODE_W-1:0] node);
      node_bit = node[5] ? hi[node[4:0]] : lo[node[4:0]];
   endfunction

   // ones in the written lanes set or clear; zero bits and other lanes untouched
   function automatic logic [DATA_W-1:0] set_clear(input logic [DATA_W-1:0] cur,
                                                   input logic [ADDR_W-1:0] addr,
                                                   input logic [ADDR_W-1:0] off_set,
                                                   input logic [ADDR_W-1:0] off_clr,
                                                   input logic fire,
                                                   input logic [DATA_W-1:0] bits);
      set_clear = cur;
      if (fire && addr == off_set) begin
         set_clear = cur | bits;
      end else if (fire && addr == off_clr) begin
         set_clear = cur & ~bits;
      end
   endfunction

   // slave: one wait cycle; read data is registered entering the answer cycle, write data lands at the edge ending it
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         bus_state_reg <= BUS_IDLE;
         avs_waitrequest <= 1'b1;
      end else begin
         case (bus_state_reg)
            BUS_IDLE: begin
               if (avs_read || avs_write) begin
                  bus_state_reg <= BUS_ANSWER;
                  avs_waitrequest <= 1'b0;
               end
            end
            BUS_ANSWER: begin
               bus_state_reg <= BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default: begin
               bus_state_reg <= BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   assign wr_fire = avs_write && (bus_state_reg == BUS_ANSWER);
   assign wr_bits = avs_writedata & {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   always_comb begin
      case (avs_address)
         OFF_ASYNC_HIGH_SET, OFF_ASYNC_HIGH_CLR: rd_value = async_high_reg;
         OFF_ASYNC_LOW_SET, OFF_ASYNC_LOW_CLR: rd_value = async_low_reg;
         OFF_PHYS_HIGH_SET, OFF_PHYS_HIGH_CLR: rd_value = phys_high_reg;
         OFF_PHYS_LOW_SET, OFF_PHYS_LOW_CLR: rd_value = phys_low_reg;
         OFF_FILTER_STATUS: rd_value = {refuse_cnt_reg, accept_cnt_reg};
         default: rd_value = FILTER_RESET;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         avs_readdata <= FILTER_RESET;
      end else if (bus_state_reg == BUS_IDLE && avs_read) begin
         avs_readdata <= rd_value;
      end
   end

   // bus reset clears first so a same-cycle software set still wins
   always_comb begin
      async_high_next = set_clear(async_high_reg, avs_address, OFF_ASYNC_HIGH_SET,
                                  OFF_ASYNC_HIGH_CLR, wr_fire, wr_bits);
      async_low_next = set_clear(async_low_reg, avs_address, OFF_ASYNC_LOW_SET,
                                 OFF_ASYNC_LOW_CLR, wr_fire, wr_bits);
      phys_high_next = set_clear(serial_bus_reset ? (phys_high_reg & REMOTE_BUS_MASK)
                                                  : phys_high_reg,
                                 avs_address, OFF_PHYS_HIGH_SET, OFF_PHYS_HIGH_CLR,
                                 wr_fire, wr_bits);
      phys_low_next = set_clear(serial_bus_reset ? FILTER_RESET : phys_low_reg,
                                avs_address, OFF_PHYS_LOW_SET, OFF_PHYS_LOW_CLR,
                                wr_fire, wr_bits);
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         async_high_reg <= FILTER_RESET;
         async_low_reg <= FILTER_RESET;
         phys_high_reg <= FILTER_RESET;
         phys_low_reg <= FILTER_RESET;
      end else begin
         async_high_reg <= async_high_next;
         async_low_reg <= async_low_next;
         phys_high_reg <= phys_high_next;
         phys_low_reg <= phys_low_next;
      end
   end

   // decision: local sources take the async pass first, then a second pass against the physical filters; nonlocal ones use the all-buses bits
   always_comb begin
      src_local = (req_src_id[SRC_W-1:NODE_W] == LOCAL_BUS_ALIAS) ||
                  (req_src_id[SRC_W-1:NODE_W] == local_bus_id);
      // broadcast node has no bit; its slot in the high word is the all-buses bit
      async_bit = (req_src_id[NODE_W-1:0] != NODE_BROADCAST) &&
                  node_bit(async_high_reg, async_low_reg, req_src_id[NODE_W-1:0]);
      phys_bit = (req_src_id[NODE_W-1:0] != NODE_BROADCAST) &&
                 node_bit(phys_high_reg, phys_low_reg, req_src_id[NODE_W-1:0]);
      if (src_local) begin
         accept_next = async_bit;
         to_phys_next = req_to_phys && async_bit && phys_bit;
      end else if (req_to_phys) begin
         accept_next = phys_high_reg[REMOTE_BUS_BIT];
         to_phys_next = phys_high_reg[REMOTE_BUS_BIT];
      end else begin
         accept_next = phys_high_reg[REMOTE_BUS_BIT] ||
                       async_high_reg[REMOTE_BUS_BIT];
         to_phys_next = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         dec_valid <= 1'b0;
         dec_accept <= 1'b0;
         dec_to_phys <= 1'b0;
         dec_to_async_ctx <= 1'b0;
      end else begin
         dec_valid <= req_valid;
         dec_accept <= req_valid && accept_next;
         dec_to_phys <= req_valid && to_phys_next;
         dec_to_async_ctx <= req_valid && accept_next && !to_phys_next;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         accept_cnt_reg <= COUNT_RESET;
         refuse_cnt_reg <= COUNT_RESET;
      end else if (req_valid) begin
         if (accept_next) begin
            accept_cnt_reg <= accept_cnt_reg + 16'h0001;
         end else begin
            refuse_cnt_reg <= refuse_cnt_reg + 16'h0001;
         end
      end
   end

   // checks
   sequence s_local_req;
      req_valid && src_local && req_src_id[NODE_W-1:0] != NODE_BROADCAST;
   endsequence

   sequence s_remote_req;
      req_valid && !src_local;
   endsequence

   sequence s_write_done(logic [ADDR_W-1:0] off);
      wr_fire && avs_address == off && avs_byteenable == 4'hF && !serial_bus_reset;
   endsequence

   property p_low_async_refuse;
      @(posedge clk_sys) disable iff (sys_rst)
      s_local_req and (req_src_id[5] == 1'b0 && !async_low_reg[req_src_id[4:0]])
      |=> dec_valid && !dec_accept && !dec_to_phys && !dec_to_async_ctx;
   endproperty
   a_low_async_refuse: assert property (p_low_async_refuse)
      else $error("local low node accepted with its async bit clear");

   property p_mid_async_accept;
      @(posedge clk_sys) disable iff (sys_rst)
      s_local_req and (req_src_id[5:0] >= 6'h02 && req_src_id[5:0] <= 6'h1D &&
                       async_low_reg[req_src_id[4:0]])
      |=> dec_accept;
   endproperty
   a_mid_async_accept: assert property (p_mid_async_accept)
      else $error("middle node refused with its async bit set");

   property p_high_phys_route;
      @(posedge clk_sys) disable iff (sys_rst)
      s_local_req and (req_to_phys && req_src_id[5] && async_high_reg[req_src_id[4:0]] &&
                       phys_high_reg[req_src_id[4:0]])
      |=> dec_to_phys && !dec_to_async_ctx;
   endproperty
   a_high_phys_route: assert property (p_high_phys_route)
      else $error("enabled high node not routed to physical context");

   property p_phys_fallback;
      @(posedge clk_sys) disable iff (sys_rst)
      s_local_req and (req_to_phys && async_bit && !phys_bit)
      |=> dec_accept && dec_to_async_ctx && !dec_to_phys;
   endproperty
   a_phys_fallback: assert property (p_phys_fallback)
      else $error("physical bit clear but request not sent to async context");

   property p_remote_no_ack;
      @(posedge clk_sys) disable iff (sys_rst)
      s_remote_req and (req_to_phys && !phys_high_reg[REMOTE_BUS_BIT]) |=> !dec_accept;
   endproperty
   a_remote_no_ack: assert property (p_remote_no_ack)
      else $error("nonlocal packet acknowledged with all-buses bit clear");

   property p_remote_accept;
      @(posedge clk_sys) disable iff (sys_rst)
      s_remote_req and phys_high_reg[REMOTE_BUS_BIT] |=> dec_accept;
   endproperty
   a_remote_accept: assert property (p_remote_accept)
      else $error("nonlocal request refused with all-buses bit set");

   property p_bus_reset_keep;
      @(posedge clk_sys) disable iff (sys_rst)
      serial_bus_reset && !wr_fire
      |=> phys_high_reg == ($past(phys_high_reg) & REMOTE_BUS_MASK) &&
          phys_low_reg == FILTER_RESET;
   endproperty
   a_bus_reset_keep: assert property (p_bus_reset_keep)
      else $error("bus reset did not keep only the all-buses bit");

   property p_set_alias;
      @(posedge clk_sys) disable iff (sys_rst)
      s_write_done(OFF_PHYS_HIGH_SET)
      |=> phys_high_reg == ($past(phys_high_reg) | $past(avs_writedata));
   endproperty
   a_set_alias: assert property (p_set_alias)
      else $error("set alias write gave wrong filter contents");

   property p_clear_alias;
      @(posedge clk_sys) disable iff (sys_rst)
      s_write_done(OFF_ASYNC_LOW_CLR)
      |=> async_low_reg == ($past(async_low_reg) & ~$past(avs_writedata));
   endproperty
   a_clear_alias: assert property (p_clear_alias)
      else $error("clear alias write gave wrong filter contents");

   property p_reset_zero;
      @(posedge clk_sys)
      sys_rst |=> async_high_reg == FILTER_RESET && async_low_reg == FILTER_RESET &&
                  phys_high_reg == FILTER_RESET && phys_low_reg == FILTER_RESET;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("filter bits not zero after reset");

   property p_bus_answer;
      @(posedge clk_sys) disable iff (sys_rst)
      (avs_read || avs_write) && avs_waitrequest && bus_state_reg == BUS_IDLE
      |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("bus answer not given after exactly one wait cycle");

   property p_low_phys_route;
      @(posedge clk_sys) disable iff (sys_rst)
      s_local_req and (req_to_phys && !req_src_id[5] && async_low_reg[req_src_id[4:0]] &&
                       phys_low_reg[req_src_id[4:0]])
      |=> dec_accept && dec_to_phys && !dec_to_async_ctx;
   endproperty
   a_low_phys_route: assert property (p_low_phys_route)
      else $error("enabled low node not routed to physical context");

   property p_remote_phys_route;
      @(posedge clk_sys) disable iff (sys_rst)
      s_remote_req and (req_to_phys && phys_high_reg[REMOTE_BUS_BIT])
      |=> dec_accept && dec_to_phys && !dec_to_async_ctx;
   endproperty
   a_remote_phys_route: assert property (p_remote_phys_route)
      else $error("nonlocal physical packet not served with all-buses bit set");

   // a stray decision pulse would be taken downstream as a real packet
   property p_idle_quiet;
      @(posedge clk_sys) disable iff (sys_rst)
      !req_valid |=> !dec_valid && !dec_accept && !dec_to_phys && !dec_to_async_ctx;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("decision output raised without a request");

endmodule

`default_nettype wire

/* testbench/remote_node_model.sv */
// Purpose: far-side model of remote serial bus nodes sending requests
// Assumes: one request per call, launched just after a clk_sys rising edge
// Notes: released fields are inverted so a stale value cannot pass as live
`timescale 1ns/100ps
`default_nettype none

module remote_node_model
   import request_filter_pkg::*;
(
   input wire logic clk_sys,
   output logic req_valid,
   output logic [SRC_W-1:0] req_src_id,
   output logic req_to_phys
);
   initial begin
      req_valid = 1'b0;
      req_src_id = '0;
      req_to_phys = 1'b0;
   end

   task automatic send(input logic [SRC_W-1:0] src, input logic phys);
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_src_id <= src;
      req_to_phys <= phys;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      req_src_id <= ~src;
      req_to_phys <= ~phys;
   endtask
endmodule

`default_nettype wire

/* testbench/request_node_filter_tb_top.sv */
// Purpose: self-checking bench for the per-node request filter
// Assumes: Avalon master tasks, remote node model on the request side
// Notes: shadow copies of the four filters give every expected decision
`timescale 1ns/100ps
`default_nettype none

module request_node_filter_tb_top
   import request_filter_pkg::*;
;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   logic [BUS_W-1:0] local_bus_id = 10'h012;
   logic serial_bus_reset = 1'b0;
   logic req_valid, req_to_phys, dec_valid, dec_accept, dec_to_phys, dec_to_async_ctx;
   logic [SRC_W-1:0] req_src_id;
   logic [DATA_W-1:0] flt [4] = '{default: 32'h0000_0000};
   int errors = 0;
   int cmp_count = 0;
   int acc_count = 0;
   int ref_count = 0;

   always #10 clk_sys = ~clk_sys;

   request_node_filter u_request_node_filter (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .local_bus_id(local_bus_id), .serial_bus_reset(serial_bus_reset),
      .req_valid(req_valid), .req_src_id(req_src_id), .req_to_phys(req_to_phys),
      .dec_valid(dec_valid), .dec_accept(dec_accept), .dec_to_phys(dec_to_phys),
      .dec_to_async_ctx(dec_to_async_ctx));

   remote_node_model u_remote_node_model (.clk_sys(clk_sys), .req_valid(req_valid),
      .req_src_id(req_src_id), .req_to_phys(req_to_phys));

   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [DATA_W-1:0] exp, got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // request held until waitrequest is sampled low; data taken at that edge
   task automatic bus(input logic rd, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic [3:0] be,
                      output logic [DATA_W-1:0] q);
      int n;
      @(posedge clk_sys);
      avs_address <= a;
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= d;
      avs_byteenable <= be;
      n = 0;
      // no limit of its own: only the watchdog ends a stuck wait
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // one wait cycle: waitrequest seen low at the second edge
      chk("waitrequest edges", 32'h0000_0002, 32'(n));
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [3:0] be);
      logic [DATA_W-1:0] q, m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & d;
      bus(1'b0, a, d, be, q);
      if (a >= OFF_ASYNC_HIGH_SET && a <= OFF_PHYS_LOW_CLR) begin
         if (a[2]) flt[a[4:3]] &= ~m;
         else flt[a[4:3]] |= m;
      end
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      logic [DATA_W-1:0] q;
      bus(1'b1, a, '0, 4'hF, q);
      chk("readdata", exp, q);
   endtask

   task automatic rd_all();
      for (int i = 0; i < 4; i++) begin
         rd(OFF_ASYNC_HIGH_SET + 9'(8 * i), flt[i]);
         rd(OFF_ASYNC_HIGH_CLR + 9'(8 * i), flt[i]);
      end
   endtask

   function automatic logic [2:0] expect_dec(input logic [SRC_W-1:0] s, input logic p);
      logic [5:0] nd;
      logic acc, ph;
      nd = s[5:0];
      if (s[15:6] == LOCAL_BUS_ALIAS || s[15:6] == local_bus_id) begin
         acc = (nd != NODE_BROADCAST) && (nd[5] ? flt[0][nd[4:0]] : flt[1][nd[4:0]]);
         ph = p && acc && (nd[5] ? flt[2][nd[4:0]] : flt[3][nd[4:0]]);
      end else begin
         acc = flt[2][31] || (!p && flt[0][31]);
         ph = p && acc;
      end
      return {acc, ph, acc && !ph};
   endfunction

   task automatic req(input logic [SRC_W-1:0] s, input logic p);
      logic [2:0] e;
      e = expect_dec(s, p);
      if (e[2]) begin
         acc_count++;
      end else begin
         ref_count++;
      end
      u_remote_node_model.send(s, p);
      #1;
      chk("dec_valid", 32'h1, {31'h0, dec_valid});
      chk("decision", {29'h0, e}, {29'h0, dec_accept, dec_to_phys, dec_to_async_ctx});
   endtask

   initial begin
      repeat (5000) @(posedge clk_sys);
      errors++;
      complete_run();
   end

   initial begin
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      rd_all();
      rd(9'h1FC, 32'h0000_0000);
      wr(OFF_ASYNC_LOW_SET, 32'hC3A5_5A3C, 4'hF);
      wr(OFF_ASYNC_LOW_SET, 32'hFFFF_FFFF, 4'h4);
      wr(OFF_ASYNC_LOW_CLR, 32'h00F0_0000, 4'hF);
      wr(OFF_ASYNC_HIGH_SET, 32'h5A3C_C3A5, 4'hF);
      wr(OFF_PHYS_HIGH_SET, 32'h3333_CCCC, 4'hF);
      wr(OFF_PHYS_LOW_SET, 32'h0F0F_F0F0, 4'hF);
      wr(OFF_PHYS_LOW_CLR, 32'h0000_00F0, 4'hF);
      rd_all();
      // both local encodings of the source bus (alias on even nodes, local_bus_id on odd), every node, both targets
      for (int n = 0; n < 64; n++) begin
         req({n[0] ? local_bus_id : LOCAL_BUS_ALIAS, 6'(n)}, 1'b0);
         req({n[0] ? local_bus_id : LOCAL_BUS_ALIAS, 6'(n)}, 1'b1);
      end
      for (int k = 0; k < 3; k++) begin
         if (k == 1) wr(OFF_ASYNC_HIGH_SET, REMOTE_BUS_MASK, 4'hF);
         if (k == 2) wr(OFF_ASYNC_HIGH_CLR, REMOTE_BUS_MASK, 4'hF);
         if (k == 2) wr(OFF_PHYS_HIGH_SET, REMOTE_BUS_MASK, 4'hF);
         req({10'h005, 6'h22}, 1'b0);
         req({10'h005, 6'h22}, 1'b1);
      end
      wr(OFF_PHYS_HIGH_SET, 32'hFFFF_FFFF, 4'hF);
      @(posedge clk_sys);
      serial_bus_reset <= 1'b1;
      @(posedge clk_sys);
      serial_bus_reset <= 1'b0;
      flt[2] &= REMOTE_BUS_MASK;
      flt[3] = FILTER_RESET;
      rd_all();
      req({LOCAL_BUS_ALIAS, 6'h28}, 1'b1);
      // status word: refused count above accepted count
      rd(OFF_FILTER_STATUS, {16'(ref_count), 16'(acc_count)});
      complete_run();
   end
endmodule

`default_nettype wire
